// ==== hdl/pssb_consts.svh ====
// Constants of the pipelined burst SRAM port: widths, burst order strap level, timing.
// Assumes inclusion by bare name from design files only.
`ifndef PSSB_CONSTS_SVH
`define PSSB_CONSTS_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define PSSB_ADDR_W 10
`define PSSB_LANES 4
`define PSSB_LANE_W 9
`define PSSB_BURST_W 2
`define PSSB_BURST_LEN 4

// ------------------------------------------------------------
// Strap levels and read timing
// ------------------------------------------------------------
`define PSSB_ORDER_INTERLEAVED 1'b1
`define PSSB_FIRST_WORD_CYCLES 3
`define PSSB_NEXT_WORD_CYCLES 1

`endif

// ==== hdl/pssb_pkg.sv ====
// Types shared by the burst SRAM port modules.
// Assumes no surroundings beyond the consts header.
`default_nettype none
package pssb_pkg;
  typedef enum logic [1:0] {
    PSSB_IDLE,
    PSSB_READ,
    PSSB_WRITE
  } pssb_op_e;
  typedef logic [1:0] pssb_burst_t;
endpackage : pssb_pkg
`default_nettype wire

// ==== hdl/pssb_burst_counter.sv ====
// Two-bit burst counter producing interleaved or linear low address bits.
// Assumes load and step come from already-registered controls.
`timescale 1ns/1ns
`default_nettype none
`include "pssb_consts.svh"
module pssb_burst_counter (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [1:0] start_bits,
  input wire logic step,
  input wire logic interleaved,
  output logic [1:0] low_bits
);
  logic [1:0] start;
  logic [1:0] count;
  logic [1:0] next_start;
  logic [1:0] next_count;

  always_comb begin
    next_start = start;
    next_count = count;
    if (load) begin
      next_start = start_bits;
      next_count = 2'h0;
    end else if (step) begin
      next_count = count + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start <= 2'h0;
      count <= 2'h0;
    end else begin
      start <= next_start;
      count <= next_count;
    end
  end

  // Interleaved is XOR of start and count; linear is their sum
  assign low_bits = interleaved ? (start ^ count) : (start + count);
endmodule : pssb_burst_counter
`default_nettype wire

// ==== hdl/pssb_lane_decode.sv ====
// Byte-lane write enable decode from all-lanes, qualifier and per-lane selects.
// Assumes inputs are already registered.
`timescale 1ns/1ns
`default_nettype none
`include "pssb_consts.svh"
module pssb_lane_decode #(
  parameter int LANES = `PSSB_LANES
) (
  input wire logic all_lanes_write_n,
  input wire logic lane_write_qualifier_n,
  input wire logic [LANES-1:0] lane_write_select_n,
  output logic [LANES-1:0] lane_we,
  output logic any_write
);
  always_comb begin
    if (!all_lanes_write_n) begin
      lane_we = '1;
    end else if (!lane_write_qualifier_n) begin
      lane_we = ~lane_write_select_n;
    end else begin
      lane_we = '0;
    end
    any_write = |lane_we;
  end
endmodule : pssb_lane_decode
`default_nettype wire

// ==== hdl/pssb_sram_port.sv ====
// Pipelined synchronous burst SRAM: input registers, burst counter, array,
// output register and asynchronous output enable and sleep.
// Assumes all inputs except output enable and sleep are synchronous to sys_clk.
//
// What this block does
// - Every synchronous input except burst_order_interleaved is captured in input registers on the rising edge.
// - Access starts only on an edge with either address strobe low.
// - Later burst addresses come from the counter, stepped only when step is low.
// - Burst counter is two bits; a burst covers four locations then wraps.
// - Burst order is selectable: interleaved or linear.
// - Writes complete internally after registration, without further host strobing.
// - All-lanes write low writes every byte lane regardless of selects.
// - Byte selects let a write update any combination of one to four lanes.
// - Output enable and sleep act immediately, without the clock.
// - Read data passes through an output register: pipelined read path.
// - Burst read gives first word after three cycles, then one per cycle.
// - Processor strobe and controller strobe each alone start an access.
// - Captured low two address bits load the burst counter.
// - A lane select writes only with the qualifier also low.
`timescale 1ns/1ns
`default_nettype none
`include "pssb_consts.svh"
module pssb_sram_port #(
  parameter int ADDR_W = `PSSB_ADDR_W,
  parameter int LANES = `PSSB_LANES,
  parameter int LANE_W = `PSSB_LANE_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic pipelined_chip_select_n,
  input wire logic depth_select_high,
  input wire logic depth_select_low_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_qualifier_n,
  input wire logic [LANES-1:0] lane_write_select_n,
  input wire logic [LANES*LANE_W-1:0] dq_in,
  output logic [LANES*LANE_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_interleaved
);
  localparam int WORD_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  if (ADDR_W < `PSSB_BURST_W || LANES < 1 || LANE_W < 1) begin : g_bad_params
    $error("pssb_sram_port: unsupported parameters");
  end

  // ------------------------------------------------------------
  // Input registers
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic proc_strobe_q;
  logic ctrl_strobe_q;
  logic step_q;
  logic cs_q;
  logic dsh_q;
  logic dsl_q;
  logic all_lanes_q;
  logic qualifier_q;
  logic [LANES-1:0] lane_sel_q;
  logic [WORD_W-1:0] din_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      proc_strobe_q <= 1'b1;
      ctrl_strobe_q <= 1'b1;
      step_q <= 1'b1;
      cs_q <= 1'b1;
      dsh_q <= 1'b0;
      dsl_q <= 1'b1;
      all_lanes_q <= 1'b1;
      qualifier_q <= 1'b1;
      lane_sel_q <= '1;
      din_q <= '0;
    end else begin
      addr_q <= addr;
      proc_strobe_q <= processor_addr_strobe_n;
      ctrl_strobe_q <= controller_addr_strobe_n;
      step_q <= burst_step_n;
      cs_q <= pipelined_chip_select_n;
      dsh_q <= depth_select_high;
      dsl_q <= depth_select_low_n;
      all_lanes_q <= all_lanes_write_n;
      qualifier_q <= lane_write_qualifier_n;
      lane_sel_q <= lane_write_select_n;
      din_q <= dq_in;
    end
  end

  // ------------------------------------------------------------
  // Access control
  // ------------------------------------------------------------
  logic start;
  logic selected;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic active;
  logic next_active;
  pssb_pkg::pssb_op_e op;
  pssb_pkg::pssb_op_e next_op;
  logic [LANES-1:0] lane_we;
  logic any_write;
  pssb_pkg::pssb_burst_t low_bits;

  // A strobe with the part deselected ends any running burst
  assign start = !proc_strobe_q || !ctrl_strobe_q;
  assign selected = !cs_q && dsh_q && !dsl_q;

  pssb_lane_decode #(
    .LANES(LANES)
  ) u_lanes (
    .all_lanes_write_n(all_lanes_q),
    .lane_write_qualifier_n(qualifier_q),
    .lane_write_select_n(lane_sel_q),
    .lane_we(lane_we),
    .any_write(any_write)
  );

  pssb_burst_counter u_burst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(start && selected),
    .start_bits(addr_q[1:0]),
    .step(active && !start && !step_q),
    .interleaved(burst_order_interleaved == `PSSB_ORDER_INTERLEAVED),
    .low_bits(low_bits)
  );

  always_comb begin
    next_base = base;
    next_active = active;
    if (start) begin
      next_active = selected;
      if (selected) begin
        next_base = addr_q;
      end
    end
    // Processor-strobe starts are always reads; write controls ignored then
    if (!next_active) begin
      next_op = pssb_pkg::PSSB_IDLE;
    end else if (!proc_strobe_q) begin
      next_op = pssb_pkg::PSSB_READ;
    end else if (any_write) begin
      next_op = pssb_pkg::PSSB_WRITE;
    end else begin
      next_op = pssb_pkg::PSSB_READ;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base <= '0;
      active <= 1'b0;
      op <= pssb_pkg::PSSB_IDLE;
    end else begin
      base <= next_base;
      active <= next_active;
      op <= next_op;
    end
  end

  // ------------------------------------------------------------
  // Array and output register
  // ------------------------------------------------------------
  logic [WORD_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] cur_addr;
  logic [WORD_W-1:0] rd_data;
  logic [WORD_W-1:0] dout;
  logic rd_valid;
  logic out_valid;
  logic next_rd_valid;
  logic next_out_valid;
  logic [WORD_W-1:0] wr_word;
  logic [WORD_W-1:0] next_wr_word;
  logic [LANES-1:0] wr_lanes;
  logic [LANES-1:0] next_wr_lanes;

  assign cur_addr = {base[ADDR_W-1:2], low_bits};

  // Self-timed write one stage after capture, once the burst address of the
  // captured word has settled; sleep blocks it
  always_ff @(posedge sys_clk) begin
    if (op == pssb_pkg::PSSB_WRITE && !sleep_request) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_lanes[i]) begin
          mem[cur_addr][i*LANE_W +: LANE_W] <= wr_word[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  always_comb begin
    next_rd_valid = (op == pssb_pkg::PSSB_READ) && !sleep_request;
    next_out_valid = rd_valid;
    next_wr_word = din_q;
    next_wr_lanes = lane_we;
  end

  // Array read stage then output register: 3-1-1-1 from strobe edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      rd_valid <= next_rd_valid;
      out_valid <= next_out_valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[cur_addr];
    dout <= rd_data;
    wr_word <= next_wr_word;
    wr_lanes <= next_wr_lanes;
  end

  // ------------------------------------------------------------
  // Asynchronous output enable and sleep
  // ------------------------------------------------------------
  assign dq_out = dout;
  assign dq_oe = out_valid && !output_enable_n && !sleep_request;
endmodule : pssb_sram_port
`default_nettype wire

// ==== verification/pssb_port_properties.sv ====
// Checker of read timing and output gating of the burst SRAM port.
// Assumes a bind to pssb_sram_port with its default widths.
`timescale 1ns/1ns
`default_nettype none
module pssb_port_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic pipelined_chip_select_n,
  input wire logic depth_select_high,
  input wire logic depth_select_low_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_qualifier_n,
  input wire logic [3:0] lane_write_select_n,
  input wire logic [35:0] dq_out,
  input wire logic dq_oe,
  input wire logic output_enable_n,
  input wire logic sleep_request
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire sel = !pipelined_chip_select_n && depth_select_high && !depth_select_low_n;
  wire quiet = processor_addr_strobe_n && controller_addr_strobe_n;
  wire seen = quiet && !output_enable_n && !sleep_request;
  wire cs_only = processor_addr_strobe_n && !controller_addr_strobe_n;
  sequence ps_start; !processor_addr_strobe_n && sel; endsequence
  wire no_write = all_lanes_write_n && (lane_write_qualifier_n || &lane_write_select_n);
  sequence cs_read; cs_only && sel && no_write; endsequence
  sequence wait3; seen[*3]; endsequence
  a_ps_latency: assert property (ps_start ##1 wait3 |=> dq_oe)
    else $error("no data three cycles after processor start");
  a_cs_latency: assert property (cs_read ##1 wait3 |=> dq_oe)
    else $error("no data three cycles after controller start");
  a_deselect_idle: assert property (cs_only && !sel ##1 quiet[*3] |=> !dq_oe)
    else $error("output after deselected strobe");
  a_write_no_drive: assert property (cs_only && sel && !all_lanes_write_n ##1 quiet[*3]
    |=> !dq_oe)
    else $error("output driven after a write");
  a_step_hold: assert property ((seen && burst_step_n && dq_oe)[*5] |-> $stable(dq_out))
    else $error("word changed without step");
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |-> !dq_oe)
    else $error("output driven in reset");
  a_oe_gate: assert property (output_enable_n |-> !dq_oe)
    else $error("output driven with enable high");
  a_sleep_gate: assert property (sleep_request |-> !dq_oe)
    else $error("output driven in sleep");
endmodule : pssb_port_properties
bind pssb_sram_port pssb_port_properties i_props (.sys_clk, .rst_n, .processor_addr_strobe_n,
  .controller_addr_strobe_n, .burst_step_n, .pipelined_chip_select_n, .depth_select_high,
  .depth_select_low_n, .all_lanes_write_n, .lane_write_qualifier_n, .lane_write_select_n,
  .dq_out, .dq_oe, .output_enable_n, .sleep_request);
`default_nettype wire

// ==== verification/pssb_host_model.sv ====
// Host side of the shared data bus of the burst SRAM port.
// Assumes the bench sets drive_en and drive_val just after clock edges.
`timescale 1ns/1ns
`default_nettype none
module pssb_host_model (
  input wire logic sys_clk,
  input wire logic drive_en,
  input wire logic [35:0] drive_val,
  input wire logic [35:0] dq_out,
  input wire logic dq_oe,
  output logic [35:0] dq_wire
);
  // ----------------------------------------
  // Bus resolution
  // ----------------------------------------
  logic [35:0] last = 36'h0;
  // Released bus toggles so a stale word never passes for data
  always_comb dq_wire = dq_oe ? dq_out : (drive_en ? drive_val : ~last);
  always @(posedge sys_clk) last <= dq_wire;
endmodule : pssb_host_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench of the pipelined burst SRAM port.
// Assumes default widths: 10-bit word address, four 9-bit lanes.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n;
  logic [9:0] addr = 10'h0;
  logic processor_addr_strobe_n = 1'b1;
  logic controller_addr_strobe_n = 1'b1;
  logic burst_step_n = 1'b1;
  logic pipelined_chip_select_n = 1'b0;
  logic depth_select_high = 1'b1;
  logic depth_select_low_n = 1'b0;
  logic all_lanes_write_n = 1'b1;
  logic lane_write_qualifier_n = 1'b1;
  logic [3:0] lane_write_select_n = 4'hf;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_order_interleaved = 1'b0;
  logic drive_en = 1'b0;
  logic [35:0] drive_val = 36'h0;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic dq_oe;
  logic [35:0] mem [1024];
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  pssb_sram_port i_dut (.sys_clk, .rst_n, .addr, .processor_addr_strobe_n,
    .controller_addr_strobe_n, .burst_step_n, .pipelined_chip_select_n, .depth_select_high,
    .depth_select_low_n, .all_lanes_write_n, .lane_write_qualifier_n, .lane_write_select_n,
    .dq_in, .dq_out, .dq_oe, .output_enable_n, .sleep_request, .burst_order_interleaved);
  pssb_host_model i_host (.sys_clk, .drive_en, .drive_val, .dq_out, .dq_oe, .dq_wire(dq_in));
  // ----------------------------------------
  // Drivers and scenarios
  // ----------------------------------------
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [9:0] nth(input logic [9:0] a, input int i, input logic il);
    return il ? a ^ 10'(i) : {a[9:2], a[1:0] + 2'(i)};
  endfunction : nth
  // Address and data held valid through the strobe edge
  task automatic go(input logic p, input logic [9:0] a, input logic [5:0] wr,
      input logic [35:0] d);
    @(posedge sys_clk);
    processor_addr_strobe_n <= !p;
    controller_addr_strobe_n <= p;
    addr <= a;
    {all_lanes_write_n, lane_write_qualifier_n, lane_write_select_n} <= wr;
    // Outputs off so the host's write word owns the bus at the strobe edge
    output_enable_n <= !(&wr);
    drive_en <= !(&wr);
    drive_val <= d;
    @(posedge sys_clk);
    processor_addr_strobe_n <= 1'b1;
    controller_addr_strobe_n <= 1'b1;
    {all_lanes_write_n, lane_write_qualifier_n, lane_write_select_n} <= 6'h3f;
    drive_en <= 1'b0;
    output_enable_n <= 1'b0;
  endtask : go
  task automatic rd(input logic p, input logic [9:0] a, output logic [35:0] w [4]);
    go(p, a, 6'h3f, 36'h0);
    burst_step_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      w[i] = dq_out;
      @(posedge sys_clk);
    end
    burst_step_n <= 1'b1;
  endtask : rd
  task automatic t_bursts();
    logic [35:0] w [4];
    for (int a = 16; a < 20; a++) begin
      mem[a] = {9'(a), ~9'(a), 9'(a) ^ 9'h155, 9'(a) ^ 9'h0aa};
      go(1'b0, 10'(a), 6'h1f, mem[a]);
    end
    repeat (4) @(posedge sys_clk);
    for (int il = 0; il < 2; il++) begin
      burst_order_interleaved <= il[0];
      rd(!il[0], 10'h11, w);
      for (int i = 0; i < 4; i++) chk(w[i], mem[nth(10'h11, i, il[0])]);
    end
  endtask : t_bursts
  task automatic t_lanes();
    logic [35:0] w [4];
    logic [35:0] d;
    logic [5:0] wr [5] = '{6'h1f, 6'h2e, 6'h2c, 6'h30, 6'h20};
    for (int k = 0; k < 5; k++) begin
      d = 36'h9_8765_4321 >> k;
      go(1'b0, 10'h20, wr[k], d);
      for (int i = 0; i < 4; i++)
        if (!wr[k][5] || (!wr[k][4] && !wr[k][i])) mem[32][9*i +: 9] = d[9*i +: 9];
      rd(1'b1, 10'h20, w);
      chk(w[0], mem[32]);
    end
  endtask : t_lanes
  task automatic t_async();
    go(1'b1, 10'h12, 6'h3f, 36'h0);
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(dq_out, mem[18]);
    chk(36'(dq_oe), 36'h1);
    output_enable_n = 1'b1;
    #1 chk(36'(dq_oe), 36'h0);
    output_enable_n = 1'b0;
    #1 chk(36'(dq_oe), 36'h1);
    sleep_request = 1'b1;
    #1 chk(36'(dq_oe), 36'h0);
    sleep_request = 1'b0;
  endtask : t_async
  task automatic t_deselect();
    logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
    for (int k = 0; k < 3; k++) begin
      go(1'b1, 10'h13, 6'h3f, 36'h0);
      repeat (5) @(posedge sys_clk);
      {pipelined_chip_select_n, depth_select_high, depth_select_low_n} <= bad[k];
      go(1'b0, 10'h13, 6'h3f, 36'h0);
      {pipelined_chip_select_n, depth_select_high, depth_select_low_n} <= 3'b010;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(36'(dq_oe), 36'h0);
    end
  endtask : t_deselect
  task automatic final_report();
    $display("Checks made %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  initial begin
    // Falling from unknown applies the asynchronous reset before the first edge
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_bursts();
    t_lanes();
    t_async();
    t_deselect();
    final_report();
  end
endmodule : testbench
`default_nettype wire
